// *** host_adaptor_defs.svh ***
// offsets, field positions, reset values and timing counts of the adaptor
// assumes inclusion by the package and the adaptor module only
`ifndef HOST_ADAPTOR_DEFS_SVH
`define HOST_ADAPTOR_DEFS_SVH

// ****************************************************************
// register offsets inside the 2 kbyte window
// ****************************************************************
`define OFS_TIMER_ZERO   11'h401
`define OFS_TIMER_ONE    11'h403
`define OFS_TIMER_TWO    11'h405
`define OFS_TIMER_CTRL   11'h407
`define OFS_CTRL_STATUS  11'h409
`define OFS_INT_VECTOR   11'h441
`define WINDOW_BASE      16'h6000

// ****************************************************************
// host_control_status fields
// ****************************************************************
`define CSR_PAGE_MSB     4
`define CSR_SERVO_BIT    5
`define CSR_PANIC_BIT    6
`define CSR_ARM_BIT      7
`define CSR_RESET        8'h00
`define HIGH_BYTE_FILL   8'hff

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ          25
`define SYSCLK_MHZ       8
`define IO_STROBE_NS     500
`define IO_STROBE_CYC    ((`IO_STROBE_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** host_adaptor_pkg.sv ***
// types shared by the adaptor design
// assumes host_adaptor_defs.svh is on the include path
`include "host_adaptor_defs.svh"

package host_adaptor_pkg;

	// access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_IOCYC = 2'b01,
		ST_ACK   = 2'b10
	} access_state_t;

	// one decoded host request
	typedef struct packed {
		logic        write;
		logic        word;
		logic [10:1] offset;
		logic [7:0]  wdata;
	} host_req_t;

	// one timer channel
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic        msb_next;
		logic        out;
	} timer_chan_t;

endpackage : host_adaptor_pkg

// *** host_adaptor.sv ***
// host adaptor: VME byte window onto PC I/O cycles and local registers
// assumes VME and PC pins are asynchronous to clk and pass two flops here
`include "host_adaptor_defs.svh"

// Behaviour
// - answer only odd-address byte and word transfers
// - word access moves low byte, high reads 0xff
// - A10 low forwards as PC I/O cycle
// - VME A01..A05 drive PC A00..A04
// - VME A06..A09 drive PC A10..A13
// - PC A05..A09 from control, A14/A15 zero
// - A10 high selects local registers
// - vector register write-only at 0x441
// - timer registers at 0x401..0x407
// - control/status register at 0x409
// - servo clock is timer 1 chained off timer 0
// - system clock selectable 8/4/2/1 MHz, forwarded
// - all timer gates always on
// - servo clock drives PC DMA request three
// - servo clock also clocks timer 2
// - panic is PC panic or estop; edge latches
// - arm bit low holds latches clear
// - armed rising edges set sticky latches
// - bits 5,6 read latch states
// - written bits 5,6 enable interrupt request
// - reset forwarded, clears control/status to zero
module host_adaptor #(
	parameter logic [15:0] WINDOW_BASE = `WINDOW_BASE,
	parameter int          STROBE_CYC  = `IO_STROBE_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [15:1] vme_addr,
	input  wire logic        vme_as_n,
	input  wire logic        vme_ds0_n,
	input  wire logic        vme_ds1_n,
	input  wire logic        vme_write_n,
	input  wire logic        vme_iack_n,
	input  wire logic [15:0] vme_data_in,
	output logic      [15:0] vme_data_out,
	output logic             vme_data_oe,
	output logic             vme_dtack_n,
	output logic             vme_irq_n,
	input  wire logic [1:0]  sysclk_div_sel,
	output logic      [15:0] pc_addr,
	input  wire logic [7:0]  pc_data_in,
	output logic      [7:0]  pc_data_out,
	output logic             pc_data_oe,
	output logic             pc_ior_n,
	output logic             pc_iow_n,
	output logic             pc_reset,
	output logic             pc_sysclk,
	output logic             pc_drq3,
	input  wire logic        pc_panic,
	input  wire logic        estop_active,
	output logic             servo_clock_pulse
);

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	localparam int SW = 15 + 5 + 16 + 8 + 2 + 2;
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	logic [15:1]   s_addr;
	logic          s_as_n, s_ds0_n, s_ds1_n, s_wr_n, s_iack_n;
	logic [15:0]   s_vdata;
	logic [7:0]    s_pdata;
	logic [1:0]    s_div;
	logic          s_panic, s_estop;

	// two flops on every asynchronous pin
	always_ff @(posedge clk) begin
		sync1_ff <= {vme_addr, vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n,
		             vme_iack_n, vme_data_in, pc_data_in, sysclk_div_sel,
		             pc_panic, estop_active};
		sync2_ff <= sync1_ff;
	end
	assign {s_addr, s_as_n, s_ds0_n, s_ds1_n, s_wr_n, s_iack_n, s_vdata,
	        s_pdata, s_div, s_panic, s_estop} = sync2_ff;

	// ****************************************************************
	// system clock generation
	// ****************************************************************
	logic [4:0] phase_ff;
	logic [2:0] half_ff;
	logic       half_tick;
	logic       sysclk_ff;
	logic       sys_tick;
	logic [2:0] div_mask;

	// half periods of 8 MHz by phase accumulation on the 25 MHz clock
	assign half_tick = ({1'b0, phase_ff} + 6'(2 * `SYSCLK_MHZ))
	                   >= 6'(`CLK_MHZ);
	always_ff @(posedge clk) begin
		if (sys_rst)
			phase_ff <= '0;
		else if (half_tick)
			phase_ff <= 5'({1'b0, phase_ff} + 6'(2 * `SYSCLK_MHZ)
			               - 6'(`CLK_MHZ));
		else
			phase_ff <= 5'({1'b0, phase_ff} + 6'(2 * `SYSCLK_MHZ));
	end

	// divide half ticks by 1, 2, 4 or 8 for 8/4/2/1 MHz
	assign div_mask = 3'((4'h1 << s_div) - 4'h1);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			half_ff   <= '0;
			sysclk_ff <= 1'b0;
		end else if (half_tick) begin
			half_ff <= (half_ff & div_mask) == div_mask ? 3'h0
			           : 3'(half_ff + 3'h1);
			if ((half_ff & div_mask) == div_mask)
				sysclk_ff <= ~sysclk_ff;
		end
	end
	assign sys_tick  = half_tick && ((half_ff & div_mask) == div_mask)
	                   && !sysclk_ff;
	assign pc_sysclk = sysclk_ff;

	// ****************************************************************
	// host access decode and sequencer
	// ****************************************************************
	host_adaptor_pkg::access_state_t state_ff;
	host_adaptor_pkg::host_req_t     req_ff;
	logic        strobe_on, in_window, byte_odd, word_even, take;
	logic [4:0]  strobe_ff;
	logic [7:0]  rdata_ff;
	logic [7:0]  csr_ff, vector_ff, local_rd;
	logic        iack_ack;

	assign strobe_on = !s_as_n && (!s_ds0_n || !s_ds1_n);
	assign in_window = s_addr[15:11] == WINDOW_BASE[15:11];
	assign byte_odd  = !s_ds0_n && s_ds1_n;
	assign word_even = !s_ds0_n && !s_ds1_n;
	assign take = state_ff == host_adaptor_pkg::ST_IDLE && strobe_on
	              && s_iack_n && in_window && (byte_odd || word_even);
	assign iack_ack = state_ff == host_adaptor_pkg::ST_IDLE && strobe_on
	                  && !s_iack_n && vme_irq_n == 1'b0;

	// sequencer: local registers answer at once, PC cycles hold a strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff  <= host_adaptor_pkg::ST_IDLE;
			strobe_ff <= '0;
		end else begin
			case (state_ff)
				host_adaptor_pkg::ST_IDLE: begin
					if (take && !s_addr[10]) begin
						state_ff  <= host_adaptor_pkg::ST_IOCYC;
						strobe_ff <= 5'(STROBE_CYC - 1);
					end else if (take || iack_ack)
						state_ff <= host_adaptor_pkg::ST_ACK;
				end
				host_adaptor_pkg::ST_IOCYC: begin
					if (strobe_ff == 5'h0)
						state_ff <= host_adaptor_pkg::ST_ACK;
					else
						strobe_ff <= 5'(strobe_ff - 5'h1);
				end
				host_adaptor_pkg::ST_ACK: begin
					if (!strobe_on)
						state_ff <= host_adaptor_pkg::ST_IDLE;
				end
				default: state_ff <= host_adaptor_pkg::ST_IDLE;
			endcase
		end
	end

	// capture the request
	always_ff @(posedge clk) begin
		if (sys_rst)
			req_ff <= '0;
		else if (take)
			req_ff <= '{write: !s_wr_n, word: word_even,
			            offset: s_addr[10:1], wdata: s_vdata[7:0]};
	end

	// ****************************************************************
	// PC bus drive
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_addr     <= '0;
			pc_data_out <= '0;
		end else if (take) begin
			pc_addr[4:0]   <= s_addr[5:1];
			pc_addr[13:10] <= s_addr[9:6];
			pc_addr[9:5]   <= csr_ff[`CSR_PAGE_MSB:0];
			pc_addr[15:14] <= 2'h0;
			pc_data_out    <= s_vdata[7:0];
		end
	end
	assign pc_ior_n   = !(state_ff == host_adaptor_pkg::ST_IOCYC
	                      && !req_ff.write);
	assign pc_iow_n   = !(state_ff == host_adaptor_pkg::ST_IOCYC
	                      && req_ff.write);
	assign pc_data_oe = state_ff == host_adaptor_pkg::ST_IOCYC
	                    && req_ff.write;

	// reset forwarded to the PC bus
	always_ff @(posedge clk) begin
		pc_reset <= sys_rst;
	end

	// ****************************************************************
	// interval timer unit
	// ****************************************************************
	host_adaptor_pkg::timer_chan_t tmr_ff [3];
	logic [2:0]  tick;
	logic [2:0]  out_d_ff;
	logic [15:0] latch_ff [3];
	logic [2:0]  latched_ff;
	logic        local_wr, local_rd_go;
	logic [1:0]  sel;

	assign local_wr    = take && s_addr[10] && !s_wr_n;
	assign local_rd_go = take && s_addr[10] && s_wr_n;
	assign sel         = s_addr[2:1];

	// gates are always on: each channel counts on its source edge
	assign tick[0] = sys_tick;
	assign tick[1] = tmr_ff[0].out && !out_d_ff[0];
	assign tick[2] = tmr_ff[1].out && !out_d_ff[1];

	always_ff @(posedge clk) begin
		if (sys_rst)
			out_d_ff <= '1; // matches idle-high outputs, no false tick
		else
			out_d_ff <= {tmr_ff[2].out, tmr_ff[1].out, tmr_ff[0].out};
	end

	// rate generators: output low for one count, then reload
	for (genvar i = 0; i < 3; i++) begin : g_tmr
		logic tsel;
		assign tsel = s_addr[10:6] == 5'h10 && s_addr[5:3] == 3'h0;
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				tmr_ff[i]   <= '{count: '0, reload: '0, msb_next: 1'b0,
				                 out: 1'b1};
				latch_ff[i] <= '0;
				latched_ff[i] <= 1'b0;
			end else begin
				if (local_wr && tsel && sel == 2'(i)) begin
					if (tmr_ff[i].msb_next) begin
						tmr_ff[i].reload[15:8] <= s_vdata[7:0];
						tmr_ff[i].count <= {s_vdata[7:0],
						                    tmr_ff[i].reload[7:0]};
					end else
						tmr_ff[i].reload[7:0] <= s_vdata[7:0];
					tmr_ff[i].msb_next <= !tmr_ff[i].msb_next;
				end else if (tick[i]) begin
					tmr_ff[i].out <= tmr_ff[i].count != 16'h0002;
					tmr_ff[i].count <= tmr_ff[i].count <= 16'h0001
					                   ? tmr_ff[i].reload
					                   : 16'(tmr_ff[i].count - 16'h0001);
				end
				// control word: bits 7:6 pick channel, 5:4 zero latches
				if (local_wr && tsel && sel == 2'h3
				    && s_vdata[7:6] == 2'(i)) begin
					if (s_vdata[5:4] == 2'h0) begin
						latch_ff[i]   <= tmr_ff[i].count;
						latched_ff[i] <= 1'b1;
					end else
						tmr_ff[i].msb_next <= 1'b0;
				end else if (local_rd_go && tsel && sel == 2'(i)) begin
					tmr_ff[i].msb_next <= !tmr_ff[i].msb_next;
					if (tmr_ff[i].msb_next)
						latched_ff[i] <= 1'b0;
				end
			end
		end
	end

	assign servo_clock_pulse = tmr_ff[1].out;
	assign pc_drq3           = tmr_ff[1].out;

	// ****************************************************************
	// control/status, vector and interrupt latches
	// ****************************************************************
	logic panic_sys, panic_d_ff, servo_d_ff;
	logic servo_lat_ff, panic_lat_ff;
	logic csr_hit, vec_hit;

	assign panic_sys = s_panic || s_estop;
	assign csr_hit   = s_addr[10:1] == 10'(`OFS_CTRL_STATUS >> 1);
	assign vec_hit   = s_addr[10] && s_addr[6];

	// written value of control/status, cleared by reset
	always_ff @(posedge clk) begin
		if (sys_rst)
			csr_ff <= `CSR_RESET;
		else if (local_wr && csr_hit)
			csr_ff <= s_vdata[7:0];
	end

	// vector is write-only
	always_ff @(posedge clk) begin
		if (sys_rst)
			vector_ff <= '0;
		else if (local_wr && vec_hit)
			vector_ff <= s_vdata[7:0];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			servo_d_ff <= 1'b1;
			panic_d_ff <= 1'b1;
		end else begin
			servo_d_ff <= servo_clock_pulse;
			panic_d_ff <= panic_sys;
		end
	end

	// sticky latches, held clear while the arm bit is low
	always_ff @(posedge clk) begin
		if (sys_rst || !csr_ff[`CSR_ARM_BIT]) begin
			servo_lat_ff <= 1'b0;
			panic_lat_ff <= 1'b0;
		end else begin
			if (servo_clock_pulse && !servo_d_ff)
				servo_lat_ff <= 1'b1;
			if (panic_sys && !panic_d_ff)
				panic_lat_ff <= 1'b1;
		end
	end

	// interrupt request from enabled latches
	always_ff @(posedge clk) begin
		if (sys_rst)
			vme_irq_n <= 1'b1;
		else
			vme_irq_n <= !((servo_lat_ff && csr_ff[`CSR_SERVO_BIT])
			              || (panic_lat_ff && csr_ff[`CSR_PANIC_BIT]));
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	always_comb begin
		local_rd = 8'h00;
		if (csr_hit)
			local_rd = {csr_ff[`CSR_ARM_BIT], panic_lat_ff, servo_lat_ff,
			            csr_ff[`CSR_PAGE_MSB:0]};
		else if (s_addr[5:3] == 3'h0 && !s_addr[6] && sel != 2'h3) begin
			if (latched_ff[sel])
				local_rd = tmr_ff[sel].msb_next ? latch_ff[sel][15:8]
				           : latch_ff[sel][7:0];
			else
				local_rd = tmr_ff[sel].msb_next ? tmr_ff[sel].count[15:8]
				           : tmr_ff[sel].count[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_ff <= '0;
		else if (iack_ack)
			rdata_ff <= vector_ff;
		else if (local_rd_go)
			rdata_ff <= local_rd;
		else if (state_ff == host_adaptor_pkg::ST_IOCYC && strobe_ff == 5'h0)
			rdata_ff <= s_pdata;
	end

	assign vme_data_out = {`HIGH_BYTE_FILL, rdata_ff};
	assign vme_data_oe  = state_ff == host_adaptor_pkg::ST_ACK
	                      && s_wr_n;
	assign vme_dtack_n  = state_ff != host_adaptor_pkg::ST_ACK;

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence armed_servo_edge;
		csr_ff[`CSR_ARM_BIT] && servo_clock_pulse && !servo_d_ff;
	endsequence

	odd_byte_only_a: assert property (@(posedge clk) disable iff (sys_rst)
		take |-> !s_ds0_n)
		else $error("access taken without odd byte strobe");
	even_byte_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(state_ff == host_adaptor_pkg::ST_IDLE && !s_ds1_n && s_ds0_n)
		|=> state_ff == host_adaptor_pkg::ST_IDLE)
		else $error("even byte access was answered");
	forward_cycle_a: assert property (@(posedge clk) disable iff (sys_rst)
		(take && !s_addr[10]) |=> !pc_ior_n || !pc_iow_n)
		else $error("low window access not forwarded");
	pc_addr_map_a: assert property (@(posedge clk) disable iff (sys_rst)
		take |=> pc_addr == {2'h0, $past(s_addr[9:6]),
		         $past(csr_ff[4:0]), $past(s_addr[5:1])})
		else $error("PC address formed wrongly");
	local_no_pc_a: assert property (@(posedge clk) disable iff (sys_rst)
		(take && s_addr[10]) |=> (pc_ior_n && pc_iow_n) [*2])
		else $error("local access reached the PC bus");
	latch_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		!csr_ff[`CSR_ARM_BIT] |=> !servo_lat_ff && !panic_lat_ff)
		else $error("latch set while disarmed");
	servo_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
		armed_servo_edge ##1 csr_ff[`CSR_ARM_BIT] |-> servo_lat_ff)
		else $error("servo edge not latched");
	irq_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
		(servo_lat_ff && csr_ff[`CSR_SERVO_BIT]) |=> !vme_irq_n)
		else $error("enabled servo latch gave no request");
	drq_servo_a: assert property (@(posedge clk) disable iff (sys_rst)
		pc_drq3 == servo_clock_pulse)
		else $error("DMA request line differs from servo clock");
	csr_reset_a: assert property (@(posedge clk)
		sys_rst |=> csr_ff == 8'h00 && pc_reset)
		else $error("reset did not clear control/status");

endmodule : host_adaptor

// *** pc_card_model.sv ***
// pc bus card model: answers i/o reads, records i/o writes
// assumes strobes and address come from the adaptor's pc side
module pc_card_model #(
	parameter int DATA_DLY = 30
) (
	input  wire logic [15:0] pc_addr,
	input  wire logic [7:0]  pc_data_out,
	input  wire logic        pc_ior_n,
	input  wire logic        pc_iow_n,
	output logic      [7:0]  pc_data_in,
	output logic      [15:0] seen_addr,
	output logic      [7:0]  seen_data
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// read side: pattern after access time, inverted while released
	// ****************************************************************
	initial begin
		pc_data_in = 8'h00;
		forever begin
			@(negedge pc_ior_n);
			pc_data_in = ~pc_data_in;
			#(DATA_DLY) pc_data_in = pc_addr[7:0] ^ 8'h3c;
			@(posedge pc_ior_n);
			pc_data_in = ~pc_data_in;
		end
	end

	// record each i/o write at the trailing edge of its strobe
	always @(posedge pc_iow_n) begin
		seen_addr <= pc_addr;
		seen_data <= pc_data_out;
	end
endmodule : pc_card_model

// *** host_adaptor_tb_top.sv ***
// testbench of the host adaptor, vme side driven by tasks
// assumes pc_card_model stands on the pc bus side
module host_adaptor_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] BASE = 16'h6000;

	logic        clk;
	logic        sys_rst;
	logic [15:1] vme_addr;
	logic        vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n, vme_iack_n;
	logic [15:0] vme_data_in, vme_data_out, pc_addr, seen_addr;
	logic        vme_data_oe, vme_dtack_n, vme_irq_n;
	logic [1:0]  sysclk_div_sel;
	logic [7:0]  pc_data_in, pc_data_out, seen_data;
	logic        pc_data_oe, pc_ior_n, pc_iow_n, pc_reset, pc_sysclk;
	logic        pc_drq3, pc_panic, estop_active, servo_clock_pulse;
	int          error_cnt;
	int          checked;
	int          oe_bad;

	// ****************************************************************
	// clock, design and partner
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// strobe must outlast the two-flop sync of the returned pc data
	host_adaptor #(.WINDOW_BASE(BASE), .STROBE_CYC(4)) u_dut (
		.clk, .sys_rst, .vme_addr, .vme_as_n, .vme_ds0_n, .vme_ds1_n,
		.vme_write_n, .vme_iack_n, .vme_data_in, .vme_data_out,
		.vme_data_oe, .vme_dtack_n, .vme_irq_n, .sysclk_div_sel,
		.pc_addr, .pc_data_in, .pc_data_out, .pc_data_oe, .pc_ior_n,
		.pc_iow_n, .pc_reset, .pc_sysclk, .pc_drq3, .pc_panic,
		.estop_active, .servo_clock_pulse);

	pc_card_model u_card (
		.pc_addr, .pc_data_out, .pc_ior_n, .pc_iow_n, .pc_data_in,
		.seen_addr, .seen_data);

	// data enable must stand exactly while the write strobe is low
	always @(posedge clk) begin
		if ((pc_iow_n === 1'b0) !== (pc_data_oe === 1'b1))
			oe_bad++;
	end

	// ****************************************************************
	// reporting
	// ****************************************************************
	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk_val(input string name, input logic [15:0] exp,
			input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", name, exp, got);
		end
	endtask : chk_val

	task automatic chk_near(input string name, input int exp, input int got,
			input int tol);
		checked++;
		if (got < exp - tol || got > exp + tol) begin
			error_cnt++;
			$display("MISMATCH %s exp %0d got %0d", name, exp, got);
		end
	endtask : chk_near

	// ****************************************************************
	// vme cycle: hold request until dtack, release, wait dtack gone
	// ****************************************************************
	task automatic bus(input logic iack, input logic wr, input logic ds0,
			input logic ds1, input logic [15:0] a, input logic [15:0] wd,
			output logic [15:0] rd, output logic ok);
		int n;
		@(posedge clk);
		vme_addr <= a[15:1];
		vme_data_in <= wd;
		vme_write_n <= ~wr;
		vme_iack_n <= ~iack;
		vme_as_n <= 1'b0;
		vme_ds0_n <= ~ds0;
		vme_ds1_n <= ~ds1;
		ok = 1'b0;
		rd = 16'hxxxx;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clk);
			ok = (vme_dtack_n === 1'b0);
			rd = vme_data_oe ? vme_data_out : 16'hxxxx;
		end
		vme_as_n <= 1'b1;
		vme_ds0_n <= 1'b1;
		vme_ds1_n <= 1'b1;
		vme_data_in <= ~wd;
		for (n = 0; n < 40 && vme_dtack_n !== 1'b1; n++) @(posedge clk);
		@(posedge clk);
	endtask : bus

	task automatic wr8(input logic [10:0] off, input logic [7:0] d);
		logic [15:0] rd;
		logic ok;
		bus(1'b0, 1'b1, 1'b1, 1'b0, BASE | {5'h00, off}, {8'h00, d}, rd, ok);
		chk_val("write dtack", 16'h0001, ok);
	endtask : wr8

	task automatic rd8(input logic [10:0] off, input logic [15:0] exp);
		logic [15:0] rd;
		logic ok;
		bus(1'b0, 1'b0, 1'b1, 1'b0, BASE | {5'h00, off}, 16'h0000, rd, ok);
		chk_val("read dtack", 16'h0001, ok);
		chk_val("read data", exp, rd);
	endtask : rd8

	task automatic wait_irq(input int lim);
		for (int n = 0; n < lim && vme_irq_n !== 1'b0; n++) @(posedge clk);
	endtask : wait_irq

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_sysclk();
		int cnt;
		logic prev;
		for (int s = 0; s < 4; s++) begin
			sysclk_div_sel <= s[1:0];
			repeat (20) @(posedge clk);
			cnt = 0;
			prev = pc_sysclk;
			repeat (1000) begin
				@(posedge clk);
				if (prev === 1'b0 && pc_sysclk === 1'b1) cnt++;
				prev = pc_sysclk;
			end
			chk_near("sysclk edges", 320 >> s, cnt, 2);
		end
		sysclk_div_sel <= 2'h0;
		repeat (20) @(posedge clk);
	endtask : t_sysclk

	task automatic t_forward();
		logic [15:0] rd;
		logic ok;
		wr8(11'h409, 8'h15);
		rd8(11'h409, 16'hff15);
		bus(1'b0, 1'b1, 1'b1, 1'b1, BASE | 16'h02c6, 16'ha55a, rd, ok);
		chk_val("fwd ack", 16'h0001, ok);
		chk_val("pc addr", {2'b00, 4'hb, 5'h15, 5'h03}, seen_addr);
		chk_val("pc data", 16'h005a, seen_data);
		chk_val("pc data oe", 16'h0000, oe_bad[15:0]);
		bus(1'b0, 1'b0, 1'b1, 1'b1, BASE | 16'h00e2, 16'h0000, rd, ok);
		chk_val("pc read", {8'hff, 8'hb1 ^ 8'h3c}, rd);
		rd8(11'h3ff, {8'hff, 8'hbf ^ 8'h3c});
	endtask : t_forward

	task automatic t_refuse();
		logic [15:0] rd;
		logic ok;
		bus(1'b0, 1'b0, 1'b0, 1'b1, BASE | 16'h0409, 16'h0000, rd, ok);
		chk_val("even byte ack", 16'h0000, ok);
		bus(1'b0, 1'b0, 1'b1, 1'b0, 16'h4409, 16'h0000, rd, ok);
		chk_val("outside ack", 16'h0000, ok);
	endtask : t_refuse

	task automatic t_timer();
		logic prev;
		int n, falls, bad, start;
		wr8(11'h407, 8'h34);
		wr8(11'h401, 8'h04);
		wr8(11'h401, 8'h00);
		wr8(11'h407, 8'h74);
		wr8(11'h403, 8'h05);
		wr8(11'h403, 8'h00);
		prev = servo_clock_pulse;
		falls = 0;
		bad = 0;
		start = 0;
		for (n = 0; n < 2000 && falls < 5; n++) begin
			@(posedge clk);
			if (prev === 1'b1 && servo_clock_pulse === 1'b0) begin
				falls++;
				if (falls == 1) start = n;
			end
			prev = servo_clock_pulse;
			if (pc_drq3 !== servo_clock_pulse) bad++;
		end
		chk_near("servo period x4", 250, n - 1 - start, 3);
		chk_val("drq3 follows", 16'h0000, bad[15:0]);
	endtask : t_timer

	// latch timer 2 just after a servo fall, read it lsb then msb
	task automatic snap2(output logic [15:0] v);
		logic [15:0] rd;
		logic ok;
		@(negedge servo_clock_pulse);
		wr8(11'h407, 8'h80);
		bus(1'b0, 1'b0, 1'b1, 1'b0, BASE | 16'h0405, 16'h0000, rd, ok);
		v[7:0] = rd[7:0];
		bus(1'b0, 1'b0, 1'b1, 1'b0, BASE | 16'h0405, 16'h0000, rd, ok);
		v[15:8] = rd[7:0];
	endtask : snap2

	task automatic t_count2();
		logic [15:0] v0, v1;
		wr8(11'h407, 8'hb4);
		wr8(11'h405, 8'hff);
		wr8(11'h405, 8'hff);
		snap2(v0);
		repeat (3) @(negedge servo_clock_pulse);
		snap2(v1);
		chk_val("timer 2 steps", 16'h0004, 16'(v0 - v1));
	endtask : t_count2

	task automatic t_irq();
		logic [15:0] rd;
		logic ok;
		wr8(11'h441, 8'h5a);
		wr8(11'h409, 8'h60);
		repeat (300) @(posedge clk);
		rd8(11'h409, 16'hff00);
		chk_val("irq unarmed", 16'h0001, vme_irq_n);
		wr8(11'h409, 8'ha0);
		wait_irq(300);
		chk_val("servo irq", 16'h0000, vme_irq_n);
		rd8(11'h409, 16'hffa0);
		bus(1'b1, 1'b0, 1'b1, 1'b0, BASE | 16'h0409, 16'h0000, rd, ok);
		chk_val("vector", 16'h005a, rd[7:0]);
		wr8(11'h409, 8'h80);
		repeat (4) @(posedge clk);
		chk_val("irq disabled", 16'h0001, vme_irq_n);
		rd8(11'h409, 16'hffa0);
		wr8(11'h409, 8'h00);
		rd8(11'h409, 16'hff00);
		for (int s = 0; s < 2; s++) begin
			wr8(11'h409, 8'hc0);
			if (s == 0) estop_active <= 1'b1;
			else pc_panic <= 1'b1;
			wait_irq(20);
			chk_val("panic irq", 16'h0000, vme_irq_n);
			bus(1'b0, 1'b0, 1'b1, 1'b0, BASE | 16'h0409, 16'h0000, rd, ok);
			chk_val("panic latch", 16'h0003, rd[7:6]);
			estop_active <= 1'b0;
			pc_panic <= 1'b0;
			wr8(11'h409, 8'h00);
		end
	endtask : t_irq

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		error_cnt = 0;
		checked = 0;
		oe_bad = 0;
		sys_rst = 1'b1;
		vme_addr = 15'h0000;
		{vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n, vme_iack_n} = 5'h1f;
		vme_data_in = 16'h0000;
		sysclk_div_sel = 2'h0;
		pc_panic = 1'b0;
		estop_active = 1'b0;
		repeat (2) @(posedge clk);
		chk_val("pc reset on", 16'h0001, pc_reset);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk_val("pc reset off", 16'h0000, pc_reset);
		rd8(11'h409, 16'hff00);
		t_sysclk();
		t_forward();
		t_refuse();
		t_timer();
		t_count2();
		t_irq();
		end_of_test();
	end

	// cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule : host_adaptor_tb_top
